// file: src/lop_defs.svh
// constants for the latched output port host controller
//
// Functional notes
// - each data write carries one byte; sixteen outputs need two writes.
// - host ends output command by removing strobe; module then drops acknowledge.
// - data write is address phase, then a byte with the data strobe.
// - host ends a data write by removing strobe; acknowledge then drops.
// - all bus data and control lines are active low.
// - address strobe only with an address, data strobe only with data.
`ifndef LOP_DEFS_SVH
`define LOP_DEFS_SVH

// register byte offsets
`define LOP_REG_CTRL 8'h00
`define LOP_REG_DATA 8'h04
`define LOP_REG_ADDR 8'h08
`define LOP_REG_IMAGE 8'h0C
`define LOP_REG_STATUS 8'h10

// control register bits
`define LOP_CTRL_COMMAND 0
`define LOP_CTRL_WRITE 1
`define LOP_CTRL_INIT 2
`define LOP_CTRL_IMAGE 3

// status register bits
`define LOP_STAT_BUSY 0
`define LOP_STAT_TIMEOUT 1
`define LOP_STAT_NEXT_HIGH 2
`define LOP_STAT_REFUSED 3

// reset values
`define LOP_ADDR_RESET 8'h71
`define LOP_DATA_RESET 8'h00
`define LOP_IMAGE_RESET 16'h0000

// timing
`define LOP_CLK_NS 100
`define LOP_SETUP_NS 200
`define LOP_INIT_NS 1000
`define LOP_TIMEOUT_NS 100000
`define LOP_SETUP_CYC ((`LOP_SETUP_NS + `LOP_CLK_NS - 1) / `LOP_CLK_NS)
`define LOP_INIT_CYC ((`LOP_INIT_NS + `LOP_CLK_NS - 1) / `LOP_CLK_NS)
`define LOP_TIMEOUT_CYC (`LOP_TIMEOUT_NS / `LOP_CLK_NS)

`endif

// file: src/lop_pkg.sv
// types shared by the latched output port host controller
package lop_pkg;

  // sequencer states, gray coded along the usual path except the LOP_OP_REL to LOP_IDLE step
  typedef enum logic [2:0] {
    LOP_IDLE     = 3'b000,
    LOP_ADDR_SET = 3'b001,
    LOP_ADDR_WT  = 3'b011,
    LOP_ADDR_REL = 3'b010,
    LOP_OP_SET   = 3'b110,
    LOP_OP_WT    = 3'b111,
    LOP_OP_REL   = 3'b101,
    LOP_INIT     = 3'b100
  } lop_state_t;

  // kind of bus operation after the address phase
  typedef enum logic [1:0] {
    LOP_JOB_COMMAND = 2'b00,
    LOP_JOB_WRITE   = 2'b01,
    LOP_JOB_IMAGE   = 2'b10
  } lop_job_t;

endpackage

// file: src/lop_host.sv
// host controller driving a latched sixteen line output module over its strobe bus
`timescale 1ns/1ps
`default_nettype none
`include "lop_defs.svh"

module lop_host
  import lop_pkg::*;
#(
  parameter int SETUP_CYC = `LOP_SETUP_CYC,
  parameter int INIT_CYC = `LOP_INIT_CYC,
  parameter int TIMEOUT_CYC = `LOP_TIMEOUT_CYC
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic ce,
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [7:0] wb_adr,
  input wire logic [31:0] wb_dat_w,
  input wire logic [3:0] wb_sel,
  output logic [31:0] wb_dat_r,
  output logic wb_ack,
  output logic [7:0] bus_lines_n,
  output logic address_strobe_n,
  output logic data_strobe_n,
  output logic command_strobe_n,
  output logic initialize_pulse_n,
  input wire logic sync_acknowledge_n
);

  // register file and status
  logic [7:0] data_byte, next_data_byte;
  logic [7:0] mod_addr, next_mod_addr;
  logic [15:0] image, next_image;
  logic timeout_flag, next_timeout_flag;
  logic refused_flag, next_refused_flag;
  logic next_wb_ack;
  logic [31:0] next_wb_dat_r;

  // sequencer state
  lop_state_t state, next_state;
  lop_job_t job, next_job;
  logic [1:0] step, next_step;
  logic [15:0] cnt, next_cnt;
  logic next_high, next_next_high;
  logic [2:0] sync_q, next_sync_q;
  logic ack_seen, next_ack_seen;
  logic [7:0] next_bus_lines_n;
  logic next_address_strobe_n;
  logic next_data_strobe_n;
  logic next_command_strobe_n;
  logic next_initialize_pulse_n;

  // decoded bus access, taken only on the first cycle of a request
  logic wb_req, wr_ctrl, wr_stat, busy;
  logic start_cmd, start_wr, start_init, start_img;
  logic timeout_set, timeout_hit;

  assign wb_req = wb_cyc && wb_stb && !wb_ack;
  assign wr_ctrl = wb_req && wb_we && (wb_adr == `LOP_REG_CTRL) && wb_sel[0];
  assign wr_stat = wb_req && wb_we && (wb_adr == `LOP_REG_STATUS) && wb_sel[0];
  assign busy = (state != LOP_IDLE);
  assign start_cmd = wr_ctrl && !busy && wb_dat_w[`LOP_CTRL_COMMAND];
  assign start_wr = wr_ctrl && !busy && wb_dat_w[`LOP_CTRL_WRITE];
  assign start_init = wr_ctrl && !busy && wb_dat_w[`LOP_CTRL_INIT];
  assign start_img = wr_ctrl && !busy && wb_dat_w[`LOP_CTRL_IMAGE];
  // every wait has the same bound; a missing module shows as timeout, not a hang
  assign timeout_hit = (cnt >= 16'(TIMEOUT_CYC - 1));

  // register slave: one cycle answer, unmapped reads give zero
  always_comb begin
    next_wb_ack = wb_req;
    next_wb_dat_r = 32'h0000_0000;
    next_data_byte = data_byte;
    next_mod_addr = mod_addr;
    next_image = image;
    next_timeout_flag = timeout_flag;
    next_refused_flag = refused_flag;
    if (wb_req && wb_we) begin
      unique case (wb_adr)
        `LOP_REG_DATA: if (wb_sel[0]) next_data_byte = wb_dat_w[7:0];
        `LOP_REG_ADDR: if (wb_sel[0]) next_mod_addr = wb_dat_w[7:0];
        `LOP_REG_IMAGE: begin
          if (wb_sel[0]) next_image[7:0] = wb_dat_w[7:0];
          if (wb_sel[1]) next_image[15:8] = wb_dat_w[15:8];
        end
        default: ;
      endcase
    end else if (wb_req) begin
      unique case (wb_adr)
        `LOP_REG_DATA: next_wb_dat_r = {24'h000000, data_byte};
        `LOP_REG_ADDR: next_wb_dat_r = {24'h000000, mod_addr};
        `LOP_REG_IMAGE: next_wb_dat_r = {16'h0000, image};
        `LOP_REG_STATUS: begin
          next_wb_dat_r[`LOP_STAT_BUSY] = busy;
          next_wb_dat_r[`LOP_STAT_TIMEOUT] = timeout_flag;
          next_wb_dat_r[`LOP_STAT_NEXT_HIGH] = next_high;
          next_wb_dat_r[`LOP_STAT_REFUSED] = refused_flag;
        end
        default: ;
      endcase
    end
    // write one clears; a new event in the same cycle wins
    if (wr_stat && wb_dat_w[`LOP_STAT_TIMEOUT]) next_timeout_flag = 1'b0;
    if (wr_stat && wb_dat_w[`LOP_STAT_REFUSED]) next_refused_flag = 1'b0;
    if (timeout_set) next_timeout_flag = 1'b1;
    if (wr_ctrl && busy && (wb_dat_w[3:0] != 4'h0)) next_refused_flag = 1'b1;
  end

  // register file flops; ce low also holds back the bus answer
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      wb_ack <= 1'b0;
      wb_dat_r <= 32'h0000_0000;
      data_byte <= `LOP_DATA_RESET;
      mod_addr <= `LOP_ADDR_RESET;
      image <= `LOP_IMAGE_RESET;
      timeout_flag <= 1'b0;
      refused_flag <= 1'b0;
    end else if (ce) begin
      wb_ack <= next_wb_ack;
      wb_dat_r <= next_wb_dat_r;
      data_byte <= next_data_byte;
      mod_addr <= next_mod_addr;
      image <= next_image;
      timeout_flag <= next_timeout_flag;
      refused_flag <= next_refused_flag;
    end
  end

  // bus sequencer: address phase, then command or byte, each closed by its strobe
  always_comb begin
    next_state = state;
    next_job = job;
    next_step = step;
    next_cnt = cnt;
    next_next_high = next_high;
    next_bus_lines_n = bus_lines_n;
    next_address_strobe_n = address_strobe_n;
    next_data_strobe_n = data_strobe_n;
    next_command_strobe_n = command_strobe_n;
    next_initialize_pulse_n = initialize_pulse_n;
    timeout_set = 1'b0;
    // three stage sampler; the acknowledge level changes only once stages two and three agree
    next_sync_q = {sync_q[1:0], sync_acknowledge_n};
    next_ack_seen = (sync_q[1] == sync_q[2]) ? !sync_q[2] : ack_seen;
    unique case (state)
      LOP_IDLE: begin
        next_cnt = 16'h0000;
        next_step = 2'b00;
        if (start_init) begin
          next_initialize_pulse_n = 1'b0;
          next_state = LOP_INIT;
        end else if (start_cmd || start_wr || start_img) begin
          next_job = start_cmd ? LOP_JOB_COMMAND : (start_wr ? LOP_JOB_WRITE : LOP_JOB_IMAGE);
          next_bus_lines_n = ~mod_addr;
          next_state = LOP_ADDR_SET;
        end
      end
      LOP_ADDR_SET: begin
        // bus lines settle before the strobe so the module decodes a stable address
        next_cnt = cnt + 16'h0001;
        if (cnt >= 16'(SETUP_CYC - 1)) begin
          next_cnt = 16'h0000;
          next_address_strobe_n = 1'b0;
          next_state = LOP_ADDR_WT;
        end
      end
      LOP_ADDR_WT: begin
        next_cnt = cnt + 16'h0001;
        if (ack_seen) begin
          next_cnt = 16'h0000;
          next_address_strobe_n = 1'b1;
          next_state = LOP_ADDR_REL;
        end else if (timeout_hit) begin
          // no module answered: abort this job only, later jobs start afresh
          timeout_set = 1'b1;
          next_cnt = 16'h0000;
          next_address_strobe_n = 1'b1;
          next_bus_lines_n = 8'hFF;
          next_state = LOP_IDLE;
        end
      end
      LOP_ADDR_REL: begin
        // acknowledge must fall before the next strobe, else the module sees one long cycle
        next_cnt = cnt + 16'h0001;
        if (!ack_seen || timeout_hit) begin
          timeout_set = ack_seen;
          next_cnt = 16'h0000;
          // acknowledge stuck low: give up rather than strobe into a busy module
          if (ack_seen) begin
            next_bus_lines_n = 8'hFF;
            next_state = LOP_IDLE;
          end else begin
            // the selected module keeps its select flag for the operation that follows
            if ((job == LOP_JOB_COMMAND) || ((job == LOP_JOB_IMAGE) && (step == 2'b00))) begin
              next_bus_lines_n = 8'hFF;
            end else if (job == LOP_JOB_WRITE) begin
              next_bus_lines_n = ~data_byte;
            end else begin
              next_bus_lines_n = (step == 2'b01) ? ~image[7:0] : ~image[15:8];
            end
            next_state = LOP_OP_SET;
          end
        end
      end
      LOP_OP_SET: begin
        next_cnt = cnt + 16'h0001;
        if (cnt >= 16'(SETUP_CYC - 1)) begin
          next_cnt = 16'h0000;
          if ((job == LOP_JOB_COMMAND) || ((job == LOP_JOB_IMAGE) && (step == 2'b00))) begin
            next_command_strobe_n = 1'b0;
          end else begin
            next_data_strobe_n = 1'b0;
          end
          next_state = LOP_OP_WT;
        end
      end
      LOP_OP_WT: begin
        next_cnt = cnt + 16'h0001;
        if (ack_seen || timeout_hit) begin
          next_cnt = 16'h0000;
          next_command_strobe_n = 1'b1;
          next_data_strobe_n = 1'b1;
          if (ack_seen) begin
            next_state = LOP_OP_REL;
          end else begin
            // steering shadow is left as it was, it may no longer match the module
            timeout_set = 1'b1;
            next_bus_lines_n = 8'hFF;
            next_state = LOP_IDLE;
          end
        end
      end
      LOP_OP_REL: begin
        next_cnt = cnt + 16'h0001;
        if (!ack_seen || timeout_hit) begin
          timeout_set = ack_seen;
          next_cnt = 16'h0000;
          next_bus_lines_n = 8'hFF;
          // track the module's steering: command clears it, each byte toggles it
          if (!command_strobe_n || (job == LOP_JOB_COMMAND) || ((job == LOP_JOB_IMAGE) && (step == 2'b00))) begin
            next_next_high = 1'b0;
          end else begin
            next_next_high = !next_high;
          end
          if ((job == LOP_JOB_IMAGE) && (step != 2'b10) && !ack_seen) begin
            // every byte of an image needs its own address phase
            next_step = step + 2'b01;
            next_bus_lines_n = ~mod_addr;
            next_state = LOP_ADDR_SET;
          end else begin
            next_state = LOP_IDLE;
          end
        end
      end
      LOP_INIT: begin
        // the module gives no acknowledge to initialize, so the pulse is timed
        next_cnt = cnt + 16'h0001;
        if (cnt >= 16'(INIT_CYC - 1)) begin
          next_cnt = 16'h0000;
          next_initialize_pulse_n = 1'b1;
          next_next_high = 1'b0;
          next_state = LOP_IDLE;
        end
      end
    endcase
  end

  // sequencer registers; ce low holds the strobes exactly where they are
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      state <= LOP_IDLE;
      job <= LOP_JOB_COMMAND;
      step <= 2'b00;
      cnt <= 16'h0000;
      next_high <= 1'b0;
      sync_q <= 3'b111;
      ack_seen <= 1'b0;
      bus_lines_n <= 8'hFF;
      address_strobe_n <= 1'b1;
      data_strobe_n <= 1'b1;
      command_strobe_n <= 1'b1;
      initialize_pulse_n <= 1'b1;
    end else if (ce) begin
      state <= next_state;
      job <= next_job;
      step <= next_step;
      cnt <= next_cnt;
      next_high <= next_next_high;
      sync_q <= next_sync_q;
      ack_seen <= next_ack_seen;
      bus_lines_n <= next_bus_lines_n;
      address_strobe_n <= next_address_strobe_n;
      data_strobe_n <= next_data_strobe_n;
      command_strobe_n <= next_command_strobe_n;
      initialize_pulse_n <= next_initialize_pulse_n;
    end
  end

endmodule
`default_nettype wire

// file: bench/lop_host_props.sv
// assertion checker for the latched output port host controller
`timescale 1ns/1ps
`default_nettype none
module lop_host_props (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [7:0] bus_lines_n,
  input wire logic address_strobe_n,
  input wire logic data_strobe_n,
  input wire logic command_strobe_n,
  input wire logic initialize_pulse_n,
  input wire logic sync_acknowledge_n
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  logic addr_seen;
  logic next_addr_seen;
  // remember an address phase until the next data or command phase
  always_comb begin
    next_addr_seen = addr_seen;
    if (!address_strobe_n) next_addr_seen = 1'b1;
    else if (!data_strobe_n || !command_strobe_n) next_addr_seen = 1'b0;
  end
  always_ff @(posedge clk_sys) begin
    if (!resetn) addr_seen <= 1'b0;
    else addr_seen <= next_addr_seen;
  end
  a_one_strobe: assert property ($onehot0({~address_strobe_n, ~data_strobe_n, ~command_strobe_n,
    ~initialize_pulse_n})) else $error("two strobes low at once");
  a_addr_lines_hold: assert property (!address_strobe_n && $past(!address_strobe_n) |->
    $stable(bus_lines_n)) else $error("address lines moved under strobe");
  a_data_lines_hold: assert property (!data_strobe_n && $past(!data_strobe_n) |->
    $stable(bus_lines_n)) else $error("data lines moved under strobe");
  a_data_after_addr: assert property ($fell(data_strobe_n) |-> addr_seen)
    else $error("data strobe without address phase");
  a_cmd_lines_idle: assert property (!command_strobe_n |-> bus_lines_n == 8'hFF)
    else $error("lines not idle during command");
  a_cmd_release: assert property (!command_strobe_n && $fell(sync_acknowledge_n) |->
    ##[1:6] command_strobe_n) else $error("command strobe not released");
  a_data_release: assert property (!data_strobe_n && $fell(sync_acknowledge_n) |->
    ##[1:6] data_strobe_n) else $error("data strobe not released");
  a_data_after_gone: assert property ($fell(data_strobe_n) |-> $past(sync_acknowledge_n))
    else $error("data strobe while acknowledge low");
  c_data: cover property ($fell(data_strobe_n));
  c_command: cover property ($fell(command_strobe_n));
  c_init: cover property ($fell(initialize_pulse_n));
endmodule
bind lop_host lop_host_props u_props (.clk_sys(clk_sys), .resetn(resetn), .bus_lines_n(bus_lines_n),
  .address_strobe_n(address_strobe_n), .data_strobe_n(data_strobe_n), .command_strobe_n(command_strobe_n),
  .initialize_pulse_n(initialize_pulse_n), .sync_acknowledge_n(sync_acknowledge_n));
`default_nettype wire

// file: bench/lop_line_model.sv
// behavioural model of the sixteen line latched output module
`timescale 1ns/1ps
`default_nettype none
module lop_line_model #(
  parameter logic [7:0] OWN_ADDR = 8'h71
) (
  input wire logic [7:0] bus_lines_n,
  input wire logic address_strobe_n,
  input wire logic data_strobe_n,
  input wire logic command_strobe_n,
  input wire logic initialize_pulse_n,
  input wire logic slow,
  output logic sync_acknowledge_n,
  output logic [15:0] driver_on
);
  logic select_flag = 1'b0;
  logic steer_high = 1'b0;
  logic want_ack;
  // no interrupt output at all
  initial driver_on = 16'h0000;
  initial sync_acknowledge_n = 1'b1;
  // lines are active low, so the address compares inverted
  always @(negedge address_strobe_n) select_flag = (~bus_lines_n == OWN_ADDR);
  // command clears both halves and steering
  always @(negedge command_strobe_n) if (select_flag) begin
    driver_on = 16'h0000;
    steer_high = 1'b0;
  end
  // one byte per strobe; a one turns the driver on
  always @(negedge data_strobe_n) if (select_flag) begin
    if (steer_high) driver_on[15:8] = ~bus_lines_n;
    else driver_on[7:0] = ~bus_lines_n;
  end
  always @(posedge data_strobe_n) if (select_flag) steer_high = ~steer_high;
  always @(negedge initialize_pulse_n) begin
    driver_on = 16'h0000;
    select_flag = 1'b0;
    steer_high = 1'b0;
  end
  // acknowledge follows the strobe; slow mode stretches both edges
  assign want_ack = (!address_strobe_n && ~bus_lines_n == OWN_ADDR) ||
    (select_flag && (!data_strobe_n || !command_strobe_n));
  always @(want_ack) sync_acknowledge_n <= #(slow ? 700 : 30) !want_ack;
endmodule
`default_nettype wire

// file: bench/testbench.sv
// self-checking bench for the latched output port host controller
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk_sys, resetn, ce, slow, wb_cyc, wb_stb, wb_we, wb_ack;
  logic [7:0] wb_adr, bus_lines_n;
  logic [31:0] wb_dat_w, wb_dat_r, rdata;
  logic [3:0] wb_sel;
  logic address_strobe_n, data_strobe_n, command_strobe_n, initialize_pulse_n, sync_acknowledge_n;
  logic [15:0] driver_on;
  logic [7:0] bytes [3] = '{8'hA5, 8'h3C, 8'h81};
  logic [15:0] image [3] = '{16'h00A5, 16'h3CA5, 16'h3C81};
  int fail_count = 0;
  int cmp_count = 0;
  lop_host #(.SETUP_CYC(2), .INIT_CYC(2), .TIMEOUT_CYC(40)) uut (.clk_sys(clk_sys), .resetn(resetn), .ce(ce),
    .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_dat_w(wb_dat_w), .wb_sel(wb_sel),
    .wb_dat_r(wb_dat_r), .wb_ack(wb_ack), .bus_lines_n(bus_lines_n), .address_strobe_n(address_strobe_n),
    .data_strobe_n(data_strobe_n), .command_strobe_n(command_strobe_n), .initialize_pulse_n(initialize_pulse_n),
    .sync_acknowledge_n(sync_acknowledge_n));
  lop_line_model partner (.bus_lines_n(bus_lines_n), .address_strobe_n(address_strobe_n), .slow(slow),
    .data_strobe_n(data_strobe_n), .command_strobe_n(command_strobe_n), .initialize_pulse_n(initialize_pulse_n),
    .sync_acknowledge_n(sync_acknowledge_n), .driver_on(driver_on));
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // one classic cycle held until ack is sampled, then an idle cycle
  task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n;
    n = 0;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_dat_w <= dat;
    do begin
      @(posedge clk_sys);
      n++;
    end while (wb_ack !== 1'b1 && n < 20);
    rdata = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge clk_sys);
    if (n >= 20) begin
      fail_count++;
      wrap_up();
    end
  endtask
  task automatic rd_chk(input string name, input logic [7:0] adr, input logic [31:0] exp);
    xfer(1'b0, adr, 32'h0);
    check(name, rdata, exp);
  endtask
  // poll busy with a bounded count
  task automatic op(input logic [31:0] ctrl);
    int n;
    n = 0;
    if (ctrl != 32'h0) xfer(1'b1, 8'h00, ctrl);
    do begin
      xfer(1'b0, 8'h10, 32'h0);
      n++;
    end while (rdata[0] !== 1'b0 && n < 100);
    if (n >= 100) begin
      fail_count++;
      wrap_up();
    end
  endtask
  initial begin
    resetn = 1'b0;
    slow = 1'b0;
    ce = 1'b1;
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_we = 1'b0;
    wb_adr = 8'h00;
    wb_dat_w = 32'h0;
    wb_sel = 4'hF;
    repeat (4) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    rd_chk("addr", 8'h08, 32'h71);
    rd_chk("status", 8'h10, 32'h0);
    rd_chk("unmapped", 8'h20, 32'h0);
    // bytes go lower, upper, then lower again
    for (int i = 0; i < 3; i++) begin
      xfer(1'b1, 8'h04, {24'h0, bytes[i]});
      op(32'h2);
      check("outputs", driver_on, image[i]);
    end
    op(32'h1);
    check("cleared", driver_on, 16'h0000);
    rd_chk("steer", 8'h10, 32'h0);
    // slow module: image order, and a second order while busy is refused
    slow <= 1'b1;
    xfer(1'b1, 8'h0C, 32'hBEEF);
    xfer(1'b1, 8'h00, 32'h8);
    xfer(1'b1, 8'h00, 32'h2);
    op(32'h0);
    check("image", driver_on, 16'hBEEF);
    rd_chk("refused", 8'h10, 32'h8);
    xfer(1'b1, 8'h10, 32'h8);
    // another address deselects the module and times out
    slow <= 1'b0;
    xfer(1'b1, 8'h08, 32'h72);
    op(32'h2);
    check("select", partner.select_flag, 1'b0);
    check("kept", driver_on, 16'hBEEF);
    xfer(1'b0, 8'h10, 32'h0);
    check("timeout", rdata & 32'hB, 32'h2);
    xfer(1'b1, 8'h08, 32'h71);
    op(32'h2);
    check("relow", driver_on, 16'hBE81);
    op(32'h4);
    check("init", driver_on, 16'h0000);
    check("init sel", partner.select_flag, 1'b0);
    // clock enable low: a request gets no answer and changes nothing
    ce <= 1'b0;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= 1'b1;
    wb_adr <= 8'h08;
    wb_dat_w <= 32'h55;
    repeat (3) @(posedge clk_sys);
    check("frozen ack", wb_ack, 1'b0);
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    ce <= 1'b1;
    @(posedge clk_sys);
    rd_chk("frozen addr", 8'h08, 32'h71);
    // reset in mid-run restores the default address and clears sticky status
    xfer(1'b1, 8'h08, 32'h33);
    resetn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    rd_chk("reset addr", 8'h08, 32'h71);
    rd_chk("reset status", 8'h10, 32'h0);
    wrap_up();
  end
endmodule
`default_nettype wire
